// [wormhole_router_port.sv]
`default_nettype none

module wormhole_router_port #(
  parameter int NOUT = 4
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_b,
  wormhole_link_if.router                      link,
  input  wire logic                            locValid,
  input  wire wormhole_pkg::char_t             locChar,
  output logic                                 locReady,
  output logic [NOUT-1:0]                      outValid,
  output wormhole_pkg::char_t [NOUT-1:0]       outChar,
  input  wire logic [NOUT-1:0]                 outReady,
  output logic                                 malformed
);
  import wormhole_pkg::*;

  localparam int OW = (NOUT > 1) ? $clog2(NOUT) : 1;

  // ----------------------------------------------------------------
  // link reset held from the system side until the link echoes it
  // ----------------------------------------------------------------
  logic holdRst_r;
  logic lrM;
  logic lrS;
  logic echoM;
  logic echoS;
  wire  linkRst = lrS;

  always_ff @(posedge link.linkClk) begin
    lrM <= holdRst_r;
    lrS <= lrM;
  end

  always_ff @(posedge clk_sys) begin
    echoM <= lrS;
    echoS <= echoM;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      holdRst_r <= 1'b1;
    end else if (echoS) begin
      holdRst_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link side: one-character receive buffer and token issue
  // ----------------------------------------------------------------
  char_t rxHold_r;
  logic  reqTog_r;
  logic  ackTog_r;
  logic  ackM;
  logic  ackS;
  logic  ackSeen_r;
  logic  fctTog_r;
  logic  primed_r;

  always_ff @(posedge link.linkClk) begin
    ackM <= ackTog_r;
    ackS <= ackM;
  end

  always_ff @(posedge link.linkClk) begin
    if (linkRst) begin
      rxHold_r  <= '0;
      reqTog_r  <= TOG_RST;
      ackSeen_r <= TOG_RST;
      fctTog_r  <= TOG_RST;
      primed_r  <= 1'b0;
    end else begin
      if (!primed_r) begin
        primed_r <= 1'b1;
        fctTog_r <= ~fctTog_r;
      end else if (ackS != ackSeen_r) begin
        ackSeen_r <= ackS;
        fctTog_r  <= ~fctTog_r;
      end
      if (link.charValid) begin
        rxHold_r <= link.charData;
        reqTog_r <= ~reqTog_r;
      end
    end
  end

  assign link.fctToggle = fctTog_r;

  // ----------------------------------------------------------------
  // system side of the character handshake
  // ----------------------------------------------------------------
  logic reqM;
  logic reqS;

  always_ff @(posedge clk_sys) begin
    reqM <= reqTog_r;
    reqS <= reqM;
  end

  // rxHold_r is stable while a request is open, so it is read as is
  wire linkPend = !holdRst_r && (reqS != ackTog_r);

  logic  srcValid [NIN];
  char_t srcChar  [NIN];
  logic  srcReady [NIN];
  logic  srcTake  [NIN];

  assign srcValid[LINK_IN]  = linkPend;
  assign srcChar[LINK_IN]   = rxHold_r;
  assign srcValid[LOCAL_IN] = locValid;
  assign srcChar[LOCAL_IN]  = locChar;
  assign locReady           = srcReady[LOCAL_IN];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ackTog_r <= TOG_RST;
    end else if (srcTake[LINK_IN]) begin
      ackTog_r <= ~ackTog_r;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  parse_t          pst_r   [NIN];
  logic [OW-1:0]   dest_r  [NIN];
  logic            hdrOut_r[NIN];
  logic            cargo_r [NIN];
  logic [NOUT-1:0] busy_r;
  logic [NOUT-1:0] owner_r;
  logic [NOUT-1:0] prio_r;
  logic [NOUT-1:0] outValid_r;
  char_t           outChar_r [NOUT];
  logic            malformed_r;

  // ----------------------------------------------------------------
  // arbitration and forwarding
  // ----------------------------------------------------------------
  logic [NOUT-1:0] slotFree;
  logic [NOUT-1:0] grant;
  logic [NOUT-1:0] grantWho;
  logic [NOUT-1:0] load;
  logic [NOUT-1:0] freeOut;
  char_t           loadChar [NOUT];
  logic            grantIn  [NIN];

  always_comb begin
    logic req0;
    logic req1;
    req0 = 1'b0;
    req1 = 1'b0;
    for (int i = 0; i < NIN; i++) begin
      grantIn[i]  = 1'b0;
      srcReady[i] = 1'b0;
      srcTake[i]  = 1'b0;
    end
    for (int o = 0; o < NOUT; o++) begin
      slotFree[o] = !outValid_r[o] || outReady[o];
      req0 = pst_r[0] == PS_WAIT && dest_r[0] == OW'(o);
      req1 = pst_r[1] == PS_WAIT && dest_r[1] == OW'(o);
      grantWho[o] = (req0 && req1) ? prio_r[o] : req1;
      grant[o] = !busy_r[o] && (req0 || req1);
      if (grant[o]) begin
        grantIn[grantWho[o]] = 1'b1;
      end
    end
    for (int i = 0; i < NIN; i++) begin
      case (pst_r[i])
        PS_HEAD:  srcReady[i] = isEnd(srcChar[i]);
        PS_FWD:   srcReady[i] = slotFree[dest_r[i]];
        PS_SPILL: srcReady[i] = 1'b1;
        default:  srcReady[i] = 1'b0;
      endcase
      srcTake[i] = srcValid[i] && srcReady[i];
    end
    for (int o = 0; o < NOUT; o++) begin
      load[o]     = 1'b0;
      freeOut[o]  = 1'b0;
      loadChar[o] = '0;
      for (int i = 0; i < NIN; i++) begin
        if (pst_r[i] == PS_FWD && dest_r[i] == OW'(o) && srcTake[i] &&
            busy_r[o] && owner_r[o] == 1'(i)) begin
          load[o]     = 1'b1;
          loadChar[o] = srcChar[i];
          freeOut[o]  = isEnd(srcChar[i]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output ports
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int o = 0; o < NOUT; o++) begin
      if (!rst_b) begin
        outValid_r[o] <= 1'b0;
        outChar_r[o]  <= '0;
        busy_r[o]     <= 1'b0;
        owner_r[o]    <= 1'b0;
        prio_r[o]     <= 1'b0;
      end else begin
        if (load[o]) begin
          outValid_r[o] <= 1'b1;
          outChar_r[o]  <= loadChar[o];
        end else if (outReady[o]) begin
          outValid_r[o] <= 1'b0;
        end
        if (freeOut[o]) begin
          busy_r[o] <= 1'b0;
        end else if (grant[o]) begin
          busy_r[o]  <= 1'b1;
          owner_r[o] <= grantWho[o];
          prio_r[o]  <= ~grantWho[o];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // per-input packet parser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    malformed_r <= 1'b0;
    for (int i = 0; i < NIN; i++) begin
      if (!rst_b) begin
        pst_r[i]    <= PS_HEAD;
        dest_r[i]   <= '0;
        hdrOut_r[i] <= 1'b0;
        cargo_r[i]  <= 1'b0;
        malformed_r <= 1'b0;
      end else begin
        case (pst_r[i])
          PS_HEAD: begin
            if (srcTake[i]) begin
              malformed_r <= 1'b1;
            end else if (srcValid[i]) begin
              if (int'(srcChar[i][7:0]) < NOUT) begin
                dest_r[i] <= OW'(srcChar[i][7:0]);
                pst_r[i]  <= PS_WAIT;
              end else begin
                pst_r[i] <= PS_SPILL;
              end
            end
          end
          PS_WAIT: begin
            if (grantIn[i]) begin
              pst_r[i]    <= PS_FWD;
              hdrOut_r[i] <= 1'b0;
              cargo_r[i]  <= 1'b0;
            end
          end
          PS_FWD: begin
            if (srcTake[i]) begin
              if (isEnd(srcChar[i])) begin
                pst_r[i] <= PS_HEAD;
                if (!cargo_r[i]) begin
                  malformed_r <= 1'b1;
                end
              end else if (hdrOut_r[i]) begin
                cargo_r[i] <= 1'b1;
              end else begin
                hdrOut_r[i] <= 1'b1;
              end
            end
          end
          PS_SPILL: begin
            if (srcTake[i] && isEnd(srcChar[i])) begin
              pst_r[i] <= PS_HEAD;
            end
          end
          default: begin
            pst_r[i] <= PS_HEAD;
          end
        endcase
      end
    end
  end

  always_comb begin
    for (int o = 0; o < NOUT; o++) begin
      outChar[o] = outChar_r[o];
    end
  end

  assign outValid  = outValid_r;
  assign malformed = malformed_r;

endmodule

`default_nettype wire

// [wormhole_pkg.sv]
// Summary of operation
// - packet is destination, cargo, then end marker
// - destination list may hold zero or more ids
// - each destination id is one or more data
// - no separator between destination list and cargo
// - sources put at least one cargo character
// - good packets close with normal end marker
// - errored packets close with error end marker
// - first data after any end marker starts packet
// - header received, route chosen from destination byte
// - free output connects at once, cut-through
// - granted output stays busy until end marker
// - end marker forwarded releases the output
// - busy output stalls input by withholding tokens
// - full receive buffer withholds flow credit
// - one packet per connection, never interleaved
`default_nettype none

package wormhole_pkg;

  // --------------------------------------------------------------
  // character format
  // --------------------------------------------------------------
  localparam int         CHAR_W   = 9;
  localparam int         CTRL_POS = 8;
  localparam logic [7:0] CODE_EOP = 8'h00;
  localparam logic [7:0] CODE_EEP = 8'h01;

  typedef logic [CHAR_W-1:0] char_t;

  // --------------------------------------------------------------
  // router inputs and reset values
  // --------------------------------------------------------------
  localparam int   NIN      = 2;
  localparam int   LINK_IN  = 0;
  localparam int   LOCAL_IN = 1;
  localparam logic TOG_RST  = 1'b0;
  localparam int   CREDIT_W = 4;
  localparam int   DIV_HALF = 2;
  // link clock rises before the far link side has a defined toggle
  localparam int   LINK_SETTLE = 4;

  typedef enum logic [3:0] {
    PS_HEAD  = 4'b0001,
    PS_WAIT  = 4'b0010,
    PS_FWD   = 4'b0100,
    PS_SPILL = 4'b1000
  } parse_t;

  typedef enum logic [2:0] {
    TX_HEAD  = 3'b001,
    TX_FIRST = 3'b010,
    TX_CARGO = 3'b100
  } txpos_t;

  // any control character closes a packet
  function automatic logic isEnd(input char_t c);
    return c[CTRL_POS];
  endfunction

endpackage

`default_nettype wire

// [wormhole_link_if.sv]
`default_nettype none

interface wormhole_link_if;
  logic                 linkClk;
  logic                 charValid;
  wormhole_pkg::char_t  charData;
  logic                 fctToggle;

  modport node (
    output linkClk,
    output charValid,
    output charData,
    input  fctToggle
  );

  modport router (
    input  linkClk,
    input  charValid,
    input  charData,
    output fctToggle
  );
endinterface

`default_nettype wire

// [wormhole_link_node.sv]
`default_nettype none

module wormhole_link_node #(
  parameter int HALF_DIV = wormhole_pkg::DIV_HALF
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  wormhole_link_if.node            link,
  input  wire logic                txValid,
  input  wire wormhole_pkg::char_t txChar,
  output logic                     txReady,
  output logic                     emptyCargo
);
  import wormhole_pkg::*;

  // ----------------------------------------------------------------
  // link clock divider
  // ----------------------------------------------------------------
  logic [7:0] divCnt_r;
  logic       linkClk_r;
  wire        divWrap = divCnt_r == 8'(HALF_DIV - 1);
  wire        fallNow = divWrap && linkClk_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      divCnt_r  <= 8'h00;
      linkClk_r <= 1'b0;
    end else if (divWrap) begin
      divCnt_r  <= 8'h00;
      linkClk_r <= ~linkClk_r;
    end else begin
      divCnt_r <= divCnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // credit from flow control tokens
  // ----------------------------------------------------------------
  logic                fctM;
  logic                fctS;
  logic                fctSeen_r;
  logic [CREDIT_W-1:0] credit_r;
  logic                charValid_r;
  char_t               charData_r;
  txpos_t              pos_r;
  logic                emptyCargo_r;

  always_ff @(posedge clk_sys) begin
    fctM <= link.fctToggle;
    fctS <= fctM;
  end

  // ----------------------------------------------------------------
  // credit start-up
  // ----------------------------------------------------------------
  // far link side resets only once the link clock runs; its toggle is
  // unknown until then, so credit is held at zero for a few rises
  logic [2:0] settle_r;
  wire        settled = settle_r == 3'(LINK_SETTLE);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      settle_r <= 3'h0;
    end else if (!settled && divWrap && !linkClk_r) begin
      settle_r <= settle_r + 3'h1;
    end
  end

  wire tokenIn = fctS != fctSeen_r;
  // a leading end marker carries no packet, so it is not sent
  wire dropIt  = pos_r == TX_HEAD && isEnd(txChar);
  assign txReady = fallNow && (dropIt || credit_r != '0);
  wire sendNow = txValid && txReady && !dropIt;

  always_ff @(posedge clk_sys) begin
    if (!rst_b || !settled) begin
      fctSeen_r <= TOG_RST;
      credit_r  <= '0;
    end else begin
      fctSeen_r <= fctS;
      credit_r  <= credit_r + CREDIT_W'(tokenIn) - CREDIT_W'(sendNow);
    end
  end

  // ----------------------------------------------------------------
  // characters held a whole link period from the falling edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      charValid_r <= 1'b0;
      charData_r  <= '0;
    end else if (fallNow) begin
      charValid_r <= sendNow;
      if (sendNow) begin
        charData_r <= txChar;
      end
    end
  end

  // ----------------------------------------------------------------
  // packet position
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pos_r        <= TX_HEAD;
      emptyCargo_r <= 1'b0;
    end else begin
      emptyCargo_r <= 1'b0;
      if (sendNow) begin
        case (pos_r)
          TX_HEAD: begin
            pos_r <= TX_FIRST;
          end
          TX_FIRST: begin
            if (isEnd(txChar)) begin
              pos_r        <= TX_HEAD;
              emptyCargo_r <= 1'b1;
            end else begin
              pos_r <= TX_CARGO;
            end
          end
          TX_CARGO: begin
            if (isEnd(txChar)) begin
              pos_r <= TX_HEAD;
            end
          end
          default: begin
            pos_r <= TX_HEAD;
          end
        endcase
      end
    end
  end

  assign link.linkClk   = linkClk_r;
  assign link.charValid = charValid_r;
  assign link.charData  = charData_r;
  assign emptyCargo     = emptyCargo_r;

endmodule

`default_nettype wire

// [wormhole_link_sva.sv]
`default_nettype none

module wormhole_link_sva (
  input wire logic                clk_sys,
  input wire logic                rst_b,
  input wire logic                linkClk,
  input wire logic                charValid,
  input wire wormhole_pkg::char_t charData,
  input wire logic                fctToggle
);
  import wormhole_pkg::*;

  // ----------------------------------------------------------------
  // credit and packet position seen on the wire
  // ----------------------------------------------------------------
  logic [3:0] cred_r;
  logic       tgl_r;
  logic       cv_r;
  logic       inPkt_r;
  logic       lk_r;
  logic [2:0] rise_r;
  wire        settled  = rise_r == 3'(LINK_SETTLE);
  // unknown toggle level before the link side resets is not a credit
  wire        gotTok   = fctToggle != tgl_r;
  wire        sent     = charValid & ~cv_r;
  wire [3:0]  credNxt  = cred_r + {3'h0, gotTok} - {3'h0, sent};
  wire        inPktNxt = sent ? ~charData[CTRL_POS] : inPkt_r;

  always_ff @(posedge clk_sys) begin
    tgl_r   <= fctToggle;
    cv_r    <= charValid;
    lk_r    <= linkClk;
    if (!rst_b) begin
      rise_r <= 3'h0;
    end else if (!settled && linkClk && !lk_r) begin
      rise_r <= rise_r + 3'h1;
    end
    cred_r  <= (rst_b && settled) ? credNxt : 4'h0;
    inPkt_r <= rst_b ? inPktNxt : 1'b0;
  end

  // ----------------------------------------------------------------
  // link assertions
  // ----------------------------------------------------------------
  chk_clk_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(linkClk) |-> ##2 $fell(linkClk)) else $error("link clock high time");
  chk_clk_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(linkClk) |-> ##2 $rose(linkClk)) else $error("link clock low time");
  chk_valid_width: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(charValid) |-> charValid[*4] ##1 !charValid)
    else $error("character not held one link period");
  chk_data_stable: assert property (@(posedge clk_sys) disable iff (!rst_b)
    charValid && $past(charValid) |-> $stable(charData))
    else $error("character changed while valid");
  chk_valid_edge: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $changed(charValid) |-> $fell(linkClk))
    else $error("valid not aligned to link clock fall");
  chk_credit_held: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(charValid) |-> cred_r != 4'h0) else $error("sent without credit");
  chk_credit_max: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cred_r <= 4'h1) else $error("more than one credit outstanding");
  chk_lead_ctrl: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(charValid) && charData[CTRL_POS] |-> inPkt_r)
    else $error("end marker sent outside a packet");
  chk_reset_idle: assert property (@(posedge clk_sys)
    !rst_b |=> !linkClk && !charValid) else $error("link not idle in reset");
endmodule

`default_nettype wire

// [wormhole_packet_router_port_tb.sv]
`default_nettype none

module wormhole_packet_router_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wormhole_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic              clk_sys, rst_b, txValid, txReady, emptyCargo;
  logic              locValid, locReady, malformed;
  char_t             txChar, locChar;
  logic [3:0]        outValid, outReady;
  char_t [3:0]       outChar;
  int                miscompares, n_checks, nMal, nEmpty;
  char_t             got[4][$];
  localparam char_t  eopC = {1'b1, CODE_EOP};
  localparam char_t  eepC = {1'b1, CODE_EEP};

  wormhole_link_if link();
  wormhole_link_node #(.HALF_DIV(2)) u_wormhole_link_node (
    .clk_sys(clk_sys), .rst_b(rst_b), .link(link), .txValid(txValid),
    .txChar(txChar), .txReady(txReady), .emptyCargo(emptyCargo));
  wormhole_router_port #(.NOUT(4)) u_wormhole_router_port (
    .clk_sys(clk_sys), .rst_b(rst_b), .link(link), .locValid(locValid),
    .locChar(locChar), .locReady(locReady), .outValid(outValid),
    .outChar(outChar), .outReady(outReady), .malformed(malformed));
  wormhole_link_sva u_wormhole_link_sva (
    .clk_sys(clk_sys), .rst_b(rst_b), .linkClk(link.linkClk),
    .charValid(link.charValid), .charData(link.charData),
    .fctToggle(link.fctToggle));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++)
      if (outValid[i] === 1'b1 && outReady[i] === 1'b1)
        got[i].push_back(outChar[i]);
    if (malformed === 1'b1) nMal++;
    if (emptyCargo === 1'b1) nEmpty++;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic char_t d(input logic [7:0] b);
    return {1'b0, b};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // lnk selects the node's user side, otherwise the local input
  task automatic put(input bit lnk, input char_t c);
    int n = 0;
    if (lnk) begin txValid = 1'b1; txChar = c; end
    else begin locValid = 1'b1; locChar = c; end
    #1;
    while ((lnk ? txReady : locReady) !== 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      #1;
      n++;
    end
    @(negedge clk_sys);
  endtask

  task automatic sendPkt(input bit lnk, input char_t p[$]);
    foreach (p[i]) put(lnk, p[i]);
    if (lnk) txValid = 1'b0;
    else locValid = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic expectPort(input int port, input char_t e[$]);
    int n = 0;
    while (got[port].size() < e.size() && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    check("count", 32'(got[port].size()), 32'(e.size()));
    foreach (e[i])
      if (i < got[port].size()) check("char", 32'(got[port][i]), 32'(e[i]));
    got[port].delete();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic tLinkRoute;
    char_t p[$];
    p = {d(8'h01), d(8'ha5), d(8'h3c), eopC};
    sendPkt(1'b1, p);
    expectPort(1, p);
  endtask

  task automatic tLeadCtrl;
    char_t p[$];
    int    m = nMal;
    sendPkt(1'b0, {eepC});
    sendPkt(1'b1, {eopC});
    p = {d(8'h00), d(8'h77), eopC};
    sendPkt(1'b0, p);
    expectPort(0, p);
    check("malformed", 32'(nMal - m), 32'h1);
  endtask

  task automatic tEmptySpill;
    char_t p[$];
    int    m = nMal;
    int    e = nEmpty;
    p = {d(8'h02), eopC};
    sendPkt(1'b0, p);
    expectPort(2, p);
    check("malformed", 32'(nMal - m), 32'h1);
    p = {d(8'h03), eopC};
    sendPkt(1'b1, p);
    expectPort(3, p);
    check("emptyCargo", 32'(nEmpty - e), 32'h1);
    // out-of-range port: whole packet vanishes
    sendPkt(1'b0, {d(8'h09), d(8'h01), eopC});
    p = {d(8'h00), d(8'h05), eopC};
    sendPkt(1'b0, p);
    expectPort(0, p);
    check("spill", 32'(got[1].size() + got[2].size() + got[3].size()),
          32'h0);
  endtask

  // port busy with a stalled local packet; link packet must wait
  task automatic tContend(input logic [7:0] port, input char_t endC);
    char_t pl[$];
    char_t pk[$];
    logic  t0;
    pl = {d(port), d(8'h11), d(8'h12), d(8'h13), endC};
    pk = {d(port), d(8'h21), d(8'h22), eopC};
    outReady[port[1:0]] = 1'b0;
    fork sendPkt(1'b0, pl); join_none
    repeat (20) @(negedge clk_sys);
    fork sendPkt(1'b1, pk); join_none
    repeat (80) @(negedge clk_sys);
    t0 = link.fctToggle;
    repeat (150) @(negedge clk_sys);
    check("fctToggle", 32'(link.fctToggle), 32'(t0));
    check("locReady", 32'(locReady), 32'h0);
    outReady[port[1:0]] = 1'b1;
    wait fork;
    expectPort(int'(port), {pl, pk});
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    txValid = 1'b0;
    txChar = '0;
    locValid = 1'b0;
    locChar = '0;
    outReady = 4'hf;
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    // link side takes its reset only once the link clock runs
    repeat (60) @(negedge clk_sys);
    tLinkRoute();
    tLeadCtrl();
    tEmptySpill();
    tContend(8'h02, eopC);
    tContend(8'h03, eepC);
    conclude();
  end

  initial begin
    #(25.0 * 40000);
    miscompares++;
    conclude();
  end
endmodule

`default_nettype wire
